/* shared/fns_pkg.sv */
// Function
// R1 - user store holds between 0.6 and 3.3 kbit; this build holds 412 bytes
// R2 - the store is driven by serial-flash style opcodes, address and data bytes
// R3 - read and program are accepted from the JTAG, slave SPI or fabric port
// R4 - read takes a start address then streams the whole store in order
// R5 - the store stays readable and writable in every lock state
// R6 - a key-locked device returns to unlocked when the matching key is given
// R7 - permanent lock can never be left by any key or command
// R8 - once one-time-programmable is set, configuration erase and program are refused
// R9 - lock state, key and one-time-programmable flag survive every reset
package fns_pkg;
    localparam int          TAG_BYTES     = 412;    // 3.3 kbit variant
    localparam int          ADDR_W        = 9;
    localparam logic [8:0]  TAG_LAST      = 9'h19B;
    localparam int          BYTE_W        = 8;
    localparam int          FIFO_DEPTH    = 32;
    localparam int          KEY_W         = 16;
    localparam logic [7:0]  IDLE_BYTE     = 8'hFF;  // erased flash and idle fill
    // opcodes
    localparam logic [7:0]  OP_READ       = 8'h03;
    localparam logic [7:0]  OP_PROG       = 8'h02;
    localparam logic [7:0]  OP_STATUS     = 8'h05;
    localparam logic [7:0]  OP_KEY_LOCK   = 8'h4B;
    localparam logic [7:0]  OP_UNLOCK     = 8'h55;
    localparam logic [7:0]  OP_PERM_LOCK  = 8'h50;
    localparam logic [7:0]  OP_OTP_SET    = 8'h4F;
    localparam logic [7:0]  OP_CFG_ERASE  = 8'hC7;
    localparam logic [7:0]  OP_CFG_PROG   = 8'hC2;
    // status byte layout
    localparam int          STS_SEC_LSB   = 0;
    localparam int          STS_OTP_BIT   = 2;

    typedef enum logic [1:0] {
        SEC_OPEN  = 2'b00,
        SEC_KEYED = 2'b01,
        SEC_PERM  = 2'b10
    } fns_sec_t;

    typedef enum logic [2:0] {
        ST_CMD  = 3'b000,
        ST_ARG  = 3'b001,
        ST_READ = 3'b010,
        ST_PROG = 3'b011,
        ST_STAT = 3'b100,
        ST_HOLD = 3'b101
    } fns_state_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_JTAG = 2'b01,
        SRC_SPI  = 2'b10,
        SRC_FAB  = 2'b11
    } fns_src_t;
endpackage

/* logic/fns_fifo.sv */
`timescale 1ns/1ps
module fns_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW:0]      wrPtr_r;
    logic [PW:0]      rdPtr_r;
    logic             doWr;
    logic             doRd;

    // extra pointer bit tells full from empty
    assign inReady  = (wrPtr_r[PW] == rdPtr_r[PW]) || (wrPtr_r[PW-1:0] != rdPtr_r[PW-1:0]);
    assign outValid = wrPtr_r != rdPtr_r;
    assign doWr     = inValid && inReady && !flush;
    assign doRd     = outValid && outReady && !flush;
    assign outData  = store[rdPtr_r[PW-1:0]];

    // pointers; flush drops whatever a finished frame left behind
    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (doWr) wrPtr_r <= wrPtr_r + 1'b1;
            if (doRd) rdPtr_r <= rdPtr_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (doWr) store[wrPtr_r[PW-1:0]] <= inData;
    end
endmodule

/* logic/fns_note_store.sv */
`timescale 1ns/1ps
module fns_note_store
    import fns_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       jtagFrame,
    input  wire logic       jtagRxValid,
    input  wire logic [7:0] jtagRxData,
    output logic            jtagTxValid,
    input  wire logic       jtagTxReady,
    output logic      [7:0] jtagTxData,
    input  wire logic       spiSck,
    input  wire logic       spiCsN,
    input  wire logic       spiMosi,
    output logic            spiMiso,
    output logic            spiMisoOe,
    input  wire logic       fabFrame,
    input  wire logic       fabRxValid,
    input  wire logic [7:0] fabRxData,
    output logic            fabTxValid,
    input  wire logic       fabTxReady,
    output logic      [7:0] fabTxData,
    output logic      [1:0] lockState,
    output logic            otpSet,
    output logic            cfgReadAllow,
    output logic            cfgEraseStb,
    output logic            cfgProgStb,
    output logic            cfgRefusedStb,
    output logic            busy
);
    ////////////////////////////////////////////////////////////////////////////////
    // slave spi pins: two flops each before use, mode 0, msb first
    logic       sckS1_r, sckS2_r, sckD_r, csS1_r, csS2_r, mosiS1_r, mosiS2_r;
    logic [2:0] bitCnt_r;
    logic [7:0] rxShift_r, txShift_r;
    logic       spiRxStb_r;
    logic       sckRise, sckFall, spiFrame, spiLoad;

    assign sckRise  = sckS2_r && !sckD_r;
    assign sckFall  = !sckS2_r && sckD_r;
    assign spiFrame = !csS2_r;
    assign spiLoad  = sckFall && (bitCnt_r == 3'h0);

    always_ff @(posedge clk) begin
        sckS1_r  <= spiSck;
        sckS2_r  <= sckS1_r;
        csS1_r   <= spiCsN;
        csS2_r   <= csS1_r;
        mosiS1_r <= spiMosi;
        mosiS2_r <= mosiS1_r;
    end

    logic       fifoOutValid, fifoOutReady, fifoInReady, pushValid;
    logic [7:0] fifoOutData, pushData;
    fns_src_t   srcSel_r;

    // shift in on rising sck, present next bit on falling sck
    always_ff @(posedge clk) begin
        if (sys_rst || !spiFrame) begin
            sckD_r     <= 1'b0;
            bitCnt_r   <= 3'h0;
            rxShift_r  <= 8'h00;
            txShift_r  <= IDLE_BYTE;
            spiRxStb_r <= 1'b0;
        end else begin
            sckD_r     <= sckS2_r;
            spiRxStb_r <= sckRise && (bitCnt_r == 3'h7);
            if (sckRise) begin
                rxShift_r <= {rxShift_r[6:0], mosiS2_r};
                bitCnt_r  <= bitCnt_r + 3'h1;
            end
            if (spiLoad) begin
                txShift_r <= (srcSel_r == SRC_SPI && fifoOutValid) ? fifoOutData : IDLE_BYTE;
            end else if (sckFall) begin
                txShift_r <= {txShift_r[6:0], 1'b1};
            end
        end
    end

    assign spiMiso   = txShift_r[7];
    assign spiMisoOe = spiFrame && (srcSel_r == SRC_SPI);

    ////////////////////////////////////////////////////////////////////////////////
    // source selection: one port owns the store for a whole frame
    logic       frameOn, rxStb;
    logic [7:0] rxByte;

    assign frameOn = (srcSel_r == SRC_JTAG && jtagFrame) || (srcSel_r == SRC_SPI && spiFrame)
                   || (srcSel_r == SRC_FAB && fabFrame);
    assign rxStb   = (srcSel_r == SRC_JTAG && jtagFrame && jtagRxValid)
                   || (srcSel_r == SRC_SPI && spiFrame && spiRxStb_r)
                   || (srcSel_r == SRC_FAB && fabFrame && fabRxValid);
    assign rxByte  = (srcSel_r == SRC_JTAG) ? jtagRxData :
                     (srcSel_r == SRC_SPI)  ? rxShift_r  : fabRxData;
    assign fifoOutReady = (srcSel_r == SRC_JTAG && jtagTxReady)
                        || (srcSel_r == SRC_SPI && spiLoad)
                        || (srcSel_r == SRC_FAB && fabTxReady);
    assign jtagTxValid  = (srcSel_r == SRC_JTAG) && fifoOutValid;
    assign fabTxValid   = (srcSel_r == SRC_FAB) && fifoOutValid;
    assign jtagTxData   = fifoOutData;
    assign fabTxData    = fifoOutData;
    assign busy         = srcSel_r != SRC_NONE;

    // fixed priority jtag, spi, fabric; a losing port waits until the owner's frame ends
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            srcSel_r <= SRC_NONE;
        end else if (srcSel_r == SRC_NONE) begin
            if (jtagFrame)     srcSel_r <= SRC_JTAG;  // [R3]
            else if (spiFrame) srcSel_r <= SRC_SPI;   // [R3]
            else if (fabFrame) srcSel_r <= SRC_FAB;   // [R3]
        end else if (!frameOn) begin
            srcSel_r <= SRC_NONE;
        end
    end

    fns_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .flush    (!frameOn),
        .inValid  (pushValid),
        .inReady  (fifoInReady),
        .inData   (pushData),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // store and security state: no reset, they model flash cells
    // power-up values sit in the declarations so the clocked writer stays the only driver
    logic [7:0]       nvMem [0:TAG_BYTES-1] = '{default: IDLE_BYTE};  // [R1]
    fns_sec_t         secState_r = SEC_OPEN;
    fns_sec_t         secState_nxt;
    logic [KEY_W-1:0] key_r = 16'h0000;
    logic [KEY_W-1:0] key_nxt;
    logic             otp_r = 1'b0;
    logic             otp_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // command engine
    fns_state_t       state_r, state_nxt;
    logic [7:0]       cmd_r, cmd_nxt, arg_r, arg_nxt;
    logic             argCnt_r, argCnt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt, addrInc;
    logic [KEY_W-1:0] fullArg;
    logic             memWe, hasArgs, cfgOp, eraseNxt, progNxt, refuseNxt;
    logic [7:0]       statusByte;

    assign fullArg    = {arg_r, rxByte};
    assign addrInc    = (addr_r == TAG_LAST) ? 9'h000 : addr_r + 9'h001;  // [R4]
    assign hasArgs    = rxByte == OP_READ || rxByte == OP_PROG
                     || rxByte == OP_KEY_LOCK || rxByte == OP_UNLOCK;
    assign cfgOp      = rxStb && state_r == ST_CMD
                     && (rxByte == OP_CFG_ERASE || rxByte == OP_CFG_PROG);
    assign eraseNxt   = cfgOp && !otp_r && rxByte == OP_CFG_ERASE;  // [R8]
    assign progNxt    = cfgOp && !otp_r && rxByte == OP_CFG_PROG;   // [R8]
    assign refuseNxt  = cfgOp && otp_r;                             // [R8]
    assign statusByte = {5'h00, otp_r, secState_r};
    assign pushValid  = frameOn && (state_r == ST_READ || state_r == ST_STAT);
    assign pushData   = (state_r == ST_STAT) ? statusByte : nvMem[addr_r];  // [R4]

    // lock state never gates the store or the config strobes, only cfgReadAllow
    always_comb begin
        state_nxt    = state_r;
        cmd_nxt      = cmd_r;
        arg_nxt      = arg_r;
        argCnt_nxt   = argCnt_r;
        addr_nxt     = addr_r;
        secState_nxt = secState_r;
        key_nxt      = key_r;
        otp_nxt      = otp_r;
        memWe        = 1'b0;
        unique case (state_r)
            ST_CMD: if (rxStb) begin
                cmd_nxt    = rxByte;
                argCnt_nxt = 1'b0;
                state_nxt  = hasArgs ? ST_ARG : ST_HOLD;  // [R2]
                if (rxByte == OP_STATUS) state_nxt = ST_STAT;
                if (rxByte == OP_PERM_LOCK) secState_nxt = SEC_PERM;  // [R7]
                if (rxByte == OP_OTP_SET) otp_nxt = 1'b1;
            end
            ST_ARG: if (rxStb) begin
                arg_nxt    = rxByte;
                argCnt_nxt = 1'b1;
                if (argCnt_r) begin
                    state_nxt = ST_HOLD;
                    addr_nxt  = (fullArg[8:0] > TAG_LAST) ? 9'h000 : fullArg[8:0];
                    if (cmd_r == OP_READ) state_nxt = ST_READ;  // [R2] [R5]
                    if (cmd_r == OP_PROG) state_nxt = ST_PROG;  // [R5]
                    if (cmd_r == OP_KEY_LOCK && secState_r == SEC_OPEN) begin
                        secState_nxt = SEC_KEYED;
                        key_nxt      = fullArg;
                    end
                    if (cmd_r == OP_UNLOCK && secState_r == SEC_KEYED && fullArg == key_r)
                        secState_nxt = SEC_OPEN;  // [R6]
                end
            end
            ST_READ: if (fifoInReady) addr_nxt = addrInc;  // [R4]
            ST_PROG: if (rxStb) begin
                memWe    = 1'b1;
                addr_nxt = addrInc;
            end
            ST_STAT: ;
            ST_HOLD: ;
            default: state_nxt = ST_CMD;
        endcase
    end

    // frame end drops the engine back to command wait
    always_ff @(posedge clk) begin
        if (sys_rst || !frameOn) begin
            state_r  <= ST_CMD;
            cmd_r    <= 8'h00;
            arg_r    <= 8'h00;
            argCnt_r <= 1'b0;
            addr_r   <= 9'h000;
        end else begin
            state_r  <= state_nxt;
            cmd_r    <= cmd_nxt;
            arg_r    <= arg_nxt;
            argCnt_r <= argCnt_nxt;
            addr_r   <= addr_nxt;
        end
    end

    // flash-backed state ignores sys_rst on purpose
    always_ff @(posedge clk) begin
        if (!sys_rst && frameOn) begin
            secState_r <= secState_nxt;  // [R9]
            key_r      <= key_nxt;
            otp_r      <= otp_nxt;       // [R9]
            if (memWe) nvMem[addr_r] <= rxByte;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfgEraseStb   <= 1'b0;
            cfgProgStb    <= 1'b0;
            cfgRefusedStb <= 1'b0;
        end else begin
            cfgEraseStb   <= eraseNxt;
            cfgProgStb    <= progNxt;
            cfgRefusedStb <= refuseNxt;
        end
    end

    assign lockState    = secState_r;
    assign otpSet       = otp_r;
    assign cfgReadAllow = secState_r == SEC_OPEN;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence argDone;
        frameOn && state_r == ST_ARG && argCnt_r && rxStb;
    endsequence

    AST_ADDR_RANGE: assert property (addr_r <= TAG_LAST)  // [R1]
        else $error("store address out of range");
    AST_PROG_TO_ARG: assert property (frameOn && state_r == ST_CMD && rxStb
        && rxByte == OP_PROG |=> state_r == ST_ARG && cmd_r == OP_PROG)  // [R2]
        else $error("program opcode not taken");
    AST_SPI_PICK: assert property (srcSel_r == SRC_NONE && spiFrame && !jtagFrame
        |=> srcSel_r == SRC_SPI)  // [R3]
        else $error("spi port not selected");
    AST_READ_STEP: assert property (frameOn && state_r == ST_READ && fifoInReady
        |-> pushData == nvMem[addr_r] ##1 (!frameOn || addr_r == ($past(addr_r) == TAG_LAST
        ? 9'h000 : $past(addr_r) + 9'h001)))  // [R4]
        else $error("read stream out of order");
    AST_READ_LOCKED: assert property (argDone and (cmd_r == OP_READ && secState_r == SEC_PERM)
        |=> state_r == ST_READ)  // [R5]
        else $error("read blocked by lock");
    AST_UNLOCK: assert property (argDone and (cmd_r == OP_UNLOCK && secState_r == SEC_KEYED
        && fullArg == key_r) |=> secState_r == SEC_OPEN && cfgReadAllow)  // [R6]
        else $error("matching key did not unlock");
    AST_PERM_STICKS: assert property (secState_r == SEC_PERM |=> secState_r == SEC_PERM)  // [R7]
        else $error("left permanent lock");
    AST_OTP_BLOCK: assert property (otp_r |=> !cfgEraseStb && !cfgProgStb)  // [R8]
        else $error("config change passed in otp mode");
    AST_NV_KEEP: assert property (@(posedge clk) disable iff (1'b0)
        sys_rst |=> $stable(secState_r) && $stable(otp_r) && $stable(key_r))  // [R9]
        else $error("reset disturbed security state");
endmodule

/* tb/fns_spi_master.sv */
`timescale 1ns/1ps
module fns_spi_master
    import fns_pkg::*;
#(
    parameter int HALF = 10
) (
    input  wire logic clk,
    output logic      spiSck,
    output logic      spiCsN,
    output logic      spiMosi,
    input  wire logic spiMiso,
    input  wire logic spiMisoOe
);
    logic lastBit;

    ////////////////////////////////////////////////////////////////////////////
    // idle: clock parked low and select released, so nothing runs between frames
    initial begin
        spiSck  = 1'b0;
        spiCsN  = 1'b1;
        spiMosi = 1'b0;
        lastBit = 1'b0;
    end

    // select edge, then a quiet gap so the synchroniser sees it before any clock
    task automatic frame(input logic on);
        @(posedge clk);
        spiCsN <= ~on;
        repeat (2 * HALF) @(posedge clk);
    endtask

    // mode 0, msb first; the half period of HALF clocks covers engine latency
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spiMosi <= tx[i];
            repeat (HALF) @(posedge clk);
            spiSck <= 1'b1;
            // an undriven line shows no stale level: take the inverse of the last bit
            rx[i] = (spiMisoOe === 1'b1) ? spiMiso : ~lastBit;
            lastBit = rx[i];
            repeat (HALF) @(posedge clk);
            spiSck <= 1'b0;
        end
    endtask
endmodule

/* tb/flash_user_note_store_test.sv */
`timescale 1ns/1ps
module flash_user_note_store_test
    import fns_pkg::*;
;
    logic       clk, sys_rst, spiSck, spiCsN, spiMosi, spiMiso, spiMisoOe;
    logic       frm[2], rxV[2], txR[2], txV[2];
    logic [7:0] rxD[2], txD[2];
    logic [1:0] lockState, expLock;
    logic       otpSet, cfgReadAllow, cfgEraseStb, cfgProgStb, cfgRefusedStb, busy, expOtp;
    logic [7:0] mem[TAG_BYTES];
    logic [31:0] seed;
    int         miscompares, compares, nErase, nProg, nRefuse, a, n;

    fns_note_store i_dut (.clk(clk), .sys_rst(sys_rst), .jtagFrame(frm[0]),
        .jtagRxValid(rxV[0]), .jtagRxData(rxD[0]), .jtagTxValid(txV[0]),
        .jtagTxReady(txR[0]), .jtagTxData(txD[0]), .spiSck(spiSck), .spiCsN(spiCsN),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .fabFrame(frm[1]),
        .fabRxValid(rxV[1]), .fabRxData(rxD[1]), .fabTxValid(txV[1]),
        .fabTxReady(txR[1]), .fabTxData(txD[1]), .lockState(lockState), .otpSet(otpSet),
        .cfgReadAllow(cfgReadAllow), .cfgEraseStb(cfgEraseStb), .cfgProgStb(cfgProgStb),
        .cfgRefusedStb(cfgRefusedStb), .busy(busy));
    fns_spi_master i_spi (.clk(clk), .spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .spiMiso(spiMiso), .spiMisoOe(spiMisoOe));

    ////////////////////////////////////////////////////////////////////////////
    // free-running clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // strobes last one cycle, so they are counted rather than polled
    always @(posedge clk) begin
        nErase  += (cfgEraseStb === 1'b1);
        nProg   += (cfgProgStb === 1'b1);
        nRefuse += (cfgRefusedStb === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // store wraps from its last byte back to the first
    function automatic int nextAddr(input int x);
        return (x >= TAG_BYTES - 1) ? 0 : x + 1;
    endfunction
    function automatic logic [7:0] statusByte(input logic o, input logic [1:0] l);
        return {5'h00, o, l};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // own the store, then one byte every other cycle; bytes before busy would be lost
    task automatic cmd(input int p, input logic [7:0] b[$]);
        int t;
        @(posedge clk);
        frm[p] <= 1'b1;
        t = 0;
        while (busy !== 1'b1 && t < 50) begin
            @(posedge clk);
            t++;
        end
        foreach (b[i]) begin
            rxD[p] <= b[i];
            rxV[p] <= 1'b1;
            @(posedge clk);
            rxV[p] <= 1'b0;
            @(posedge clk);
        end
    endtask

    task automatic endFrame(input int p);
        frm[p] <= 1'b0;
        repeat (4) @(posedge clk);
        check("busy", 16'(busy), 16'h0000);
    endtask

    // take bytes under random stalls; stat selects the status stream over the store
    task automatic readBack(input int p, input int cnt, input int x, input logic stat);
        int k, t;
        k = 0;
        t = 0;
        while (k < cnt && t < 3000) begin
            @(posedge clk);
            if (txV[p] === 1'b1 && txR[p] === 1'b1) begin
                check("txData", 16'(txD[p]), 16'(stat ? statusByte(expOtp, expLock) : mem[x]));
                x = nextAddr(x);
                k++;
            end
            seed = lfsr(seed);
            txR[p] <= seed[0];
            t++;
        end
        check("rdCount", 16'(k), 16'(cnt));
    endtask

    task automatic prog(input int p, input int x, input int cnt);
        logic [7:0] q[$];
        q = {OP_PROG, 8'(x >> 8), 8'(x)};
        repeat (cnt) begin
            seed = lfsr(seed);
            q.push_back(seed[7:0]);
            mem[x] = seed[7:0];
            x = nextAddr(x);
        end
        cmd(p, q);
        endFrame(p);
    endtask

    // a start address beyond the store begins at the first byte
    task automatic rd(input int p, input int x, input int cnt);
        cmd(p, {OP_READ, 8'(x >> 8), 8'(x)});
        readBack(p, cnt, (x > TAG_BYTES - 1) ? 0 : x, 1'b0);
        endFrame(p);
    endtask

    task automatic sts(input int p);
        cmd(p, {OP_STATUS});
        readBack(p, 2, 0, 1'b1);
        endFrame(p);
        check("lockState", 16'(lockState), 16'(expLock));
        check("cfgReadAllow", 16'(cfgReadAllow), 16'(expLock == SEC_OPEN));
        check("otpSet", 16'(otpSet), 16'(expOtp));
    endtask

    task automatic spiRead(input int x, input int cnt);
        logic [7:0] r;
        i_spi.frame(1'b1);
        i_spi.xfer(OP_READ, r);
        check("spiFirst", 16'(r), 16'(IDLE_BYTE));
        i_spi.xfer(8'(x >> 8), r);
        i_spi.xfer(8'(x), r);
        repeat (cnt) begin
            i_spi.xfer(8'h00, r);
            check("spiData", 16'(r), 16'(mem[x]));
            x = nextAddr(x);
        end
        check("misoOe", 16'(spiMisoOe), 16'h0001);
        i_spi.frame(1'b0);
    endtask

    // program over the serial port; the model mirrors every data byte sent
    task automatic spiProg(input int x, input int cnt);
        logic [7:0] r;
        i_spi.frame(1'b1);
        i_spi.xfer(OP_PROG, r);
        i_spi.xfer(8'(x >> 8), r);
        i_spi.xfer(8'(x), r);
        repeat (cnt) begin
            seed = lfsr(seed);
            i_spi.xfer(seed[7:0], r);
            mem[x] = seed[7:0];
            x = nextAddr(x);
        end
        i_spi.frame(1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog, generous against a run of a few thousand cycles
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        finish_test;
    end

    // main sequence
    initial begin
        sys_rst = 1'b1;
        frm = '{1'b0, 1'b0};
        rxV = '{1'b0, 1'b0};
        txR = '{1'b0, 1'b0};
        rxD = '{8'h00, 8'h00};
        seed = 32'h665CDD38;
        expLock = SEC_OPEN;
        expOtp = 1'b0;
        foreach (mem[i]) mem[i] = IDLE_BYTE;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        prog(0, TAG_BYTES - 2, 4);
        rd(1, TAG_BYTES - 2, 4);
        rd(0, 16'h01FF, 2);
        repeat (3) begin
            seed = lfsr(seed);
            a = int'(seed[8:0]) % TAG_BYTES;
            n = 1 + int'(seed[12:9]);
            prog(1, a, n);
            rd(0, a, n + 40);
        end
        spiRead(TAG_BYTES - 2, 4);
        spiProg(TAG_BYTES - 1, 3);
        rd(0, TAG_BYTES - 1, 3);
        $display("test store access done");
        cmd(0, {OP_KEY_LOCK, 8'hA5, 8'h3C});
        endFrame(0);
        expLock = SEC_KEYED;
        sts(0);
        rd(1, 0, 3);
        cmd(1, {OP_UNLOCK, 8'hA5, 8'h3D});
        endFrame(1);
        sts(1);
        cmd(0, {OP_UNLOCK, 8'hA5, 8'h3C});
        endFrame(0);
        expLock = SEC_OPEN;
        sts(0);
        cmd(0, {OP_CFG_ERASE});
        endFrame(0);
        check("eraseCnt", 16'(nErase), 16'h0001);
        cmd(1, {OP_OTP_SET});
        endFrame(1);
        expOtp = 1'b1;
        cmd(1, {OP_CFG_PROG});
        endFrame(1);
        cmd(0, {OP_CFG_ERASE});
        endFrame(0);
        check("cfgStrobes", 16'(nErase + nProg), 16'h0001);
        check("refuseCnt", 16'(nRefuse), 16'h0002);
        cmd(0, {OP_PERM_LOCK});
        endFrame(0);
        expLock = SEC_PERM;
        cmd(1, {OP_UNLOCK, 8'hA5, 8'h3C});
        endFrame(1);
        sts(1);
        $display("test security done");
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        sts(0);
        prog(1, 5, 2);
        spiRead(5, 2);
        $display("test locked access done");
        // stall the host until the prefetch buffer is full, then drain one byte a cycle
        txR[0] <= 1'b0;
        cmd(0, {OP_READ, 8'h00, 8'h05});
        repeat (60) @(posedge clk);
        check("fifoHold", 16'(txD[0]), 16'(mem[5]));
        txR[0] <= 1'b1;
        a = 0;
        n = 5;
        repeat (40) begin
            @(posedge clk);
            if (txV[0] === 1'b1) begin
                check("fifoData", 16'(txD[0]), 16'(mem[n]));
                n = nextAddr(n);
                a++;
            end
        end
        check("fifoDrain", 16'(a), 16'h0028);
        endFrame(0);
        $display("test buffer done");
        finish_test;
    end
endmodule
